// ===== hdl/fbd_pkg.sv
// package: pin groups, timing constants and request kinds for the flash bus host
// Operation
// - read: select and gate low, reset high, address driven, strobe high
// - write: strobe and select low while output gate stays high
// - host waits recovery time after reset rises before reading
// - program or erase cut off by a reset is reissued by the requester, not the host
package fbd_pkg;
  localparam int ADDR_W = 20;
  localparam int DATA_W = 8;
  localparam int SECT_LSB = 16;
  localparam int CLK_NS = 10;
  // pin inputs pass this many flops before the sequencer reads them
  localparam int SYNC_CYC = 2;
  // select access time of the slowest grade
  localparam int SEL_ACC_NS = 120;
  localparam int SEL_ACC_CYC = (SEL_ACC_NS + CLK_NS - 1) / CLK_NS;
  localparam int INIT_PULSE_NS = 500;
  localparam int INIT_PULSE_CYC = (INIT_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int INIT_REC_NS = 50;
  localparam int INIT_REC_CYC = (INIT_REC_NS + CLK_NS - 1) / CLK_NS;
  localparam int WR_PULSE_NS = 50;
  localparam int WR_PULSE_CYC = (WR_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 8;

  typedef struct packed {
    logic              sel_n;
    logic              gate_n;
    logic              strobe_n;
    logic              init_n;
    logic [ADDR_W-1:0] byte_addr_in;
  } fbd_pins_type;

  typedef enum logic [1:0] {
    FBD_REQ_READ,
    FBD_REQ_WRITE,
    FBD_REQ_RESET
  } fbd_req_type;

  typedef struct packed {
    fbd_req_type       kind;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } fbd_cmd_type;
endpackage : fbd_pkg

// ===== hdl/fbd_sync.sv
// two-stage synchroniser for pin inputs
`timescale 1ns/1ns
module fbd_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         i_sys_clk,
  input  wire logic         i_reset_n,
  // async in, synced out
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  // first stage feeds only the second
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= i_async;
      sync_ff <= meta_ff;
    end
  end

  assign o_sync = sync_ff;
endmodule : fbd_sync

// ===== hdl/fbd_host.sv
// host controller driving the flash pins: read, write, reset, standby
`timescale 1ns/1ns
module fbd_host (
  // clock and reset
  input  wire logic                       i_sys_clk,
  input  wire logic                       i_reset_n,
  // request side
  input  wire logic                       i_req_valid,
  input  wire fbd_pkg::fbd_cmd_type       i_req_cmd,
  output logic                            o_req_ready,
  output logic                            o_rsp_valid,
  output logic [fbd_pkg::DATA_W-1:0]      o_rsp_data,
  output logic                            o_dev_busy,
  // flash pins
  output fbd_pkg::fbd_pins_type           o_pins,
  input  wire logic [fbd_pkg::DATA_W-1:0] i_data_io,
  output logic [fbd_pkg::DATA_W-1:0]      o_data_io,
  output logic                            o_data_io_oe,
  input  wire logic                       i_op_done_flag
);
  typedef enum logic [2:0] {
    FBD_IDLE, FBD_RD, FBD_WR, FBD_WR_END, FBD_RST, FBD_REC
  } fbd_state_type;

  fbd_state_type                     state_ff, nxt_state;
  logic [fbd_pkg::CNT_W-1:0]         cnt_ff, nxt_cnt;
  fbd_pkg::fbd_pins_type             pins_ff, nxt_pins;
  logic [fbd_pkg::DATA_W-1:0]        dout_ff, nxt_dout;
  logic                              oe_ff, nxt_oe;
  logic                              rvalid_ff, nxt_rvalid;
  logic [fbd_pkg::DATA_W-1:0]        rdata_ff, nxt_rdata;
  logic [fbd_pkg::DATA_W-1:0]        din_sync;
  logic                              busy_sync;
  logic                              busy_ff;

  // pin inputs are asynchronous to the host clock; the done flag enters
  // inverted so a synchroniser still in reset reads idle, not busy
  fbd_sync #(.W(fbd_pkg::DATA_W + 1)) u_sync (
    .i_sys_clk (i_sys_clk),
    .i_reset_n (i_reset_n),
    .i_async   ({~i_op_done_flag, i_data_io}),
    .o_sync    ({busy_sync, din_sync})
  );

  function automatic logic [fbd_pkg::CNT_W-1:0] cyc(input int n);
    cyc = fbd_pkg::CNT_W'(n);
  endfunction : cyc

  wire cnt_zero = (cnt_ff == '0);
  wire idle_take = (state_ff == FBD_IDLE) && i_req_valid;
  // sample waits two extra cycles for the synchroniser
  wire [fbd_pkg::CNT_W-1:0] rd_wait =
    cyc(fbd_pkg::SEL_ACC_CYC + fbd_pkg::SYNC_CYC);

  // sequencer: next state and pin levels
  always_comb begin
    nxt_state  = state_ff;
    nxt_cnt    = cnt_zero ? cnt_ff : cnt_ff - 1'b1;
    nxt_pins   = pins_ff;
    nxt_dout   = dout_ff;
    nxt_oe     = oe_ff;
    nxt_rvalid = 1'b0;
    nxt_rdata  = rdata_ff;
    case (state_ff)
      FBD_IDLE: begin
        // idle: select high, reset high gives standby
        // standby when idle
        nxt_pins.sel_n    = 1'b1;
        nxt_pins.gate_n   = 1'b1;
        nxt_pins.strobe_n = 1'b1;
        nxt_oe            = 1'b0;
        if (i_req_valid) begin
          nxt_pins.byte_addr_in = i_req_cmd.addr;
          case (i_req_cmd.kind)
            fbd_pkg::FBD_REQ_READ: begin
              nxt_pins.sel_n  = 1'b0;
              nxt_pins.gate_n = 1'b0;
              nxt_cnt         = rd_wait;
              nxt_state       = FBD_RD;
            end
            fbd_pkg::FBD_REQ_WRITE: begin
              // write: strobe and select low, gate high
              nxt_pins.sel_n    = 1'b0;
              nxt_pins.strobe_n = 1'b0;
              nxt_dout          = i_req_cmd.wdata;
              nxt_oe            = 1'b1;
              nxt_cnt           = cyc(fbd_pkg::WR_PULSE_CYC);
              nxt_state         = FBD_WR;
            end
            default: begin
              nxt_pins.init_n = 1'b0;
              nxt_cnt         = cyc(fbd_pkg::INIT_PULSE_CYC);
              nxt_state       = FBD_RST;
            end
          endcase
        end
      end
      FBD_RD: begin
        // wait select access time before sampling
        if (cnt_zero) begin
          nxt_rdata  = din_sync;
          nxt_rvalid = 1'b1;
          nxt_pins.sel_n  = 1'b1;
          nxt_pins.gate_n = 1'b1;
          nxt_state  = FBD_IDLE;
        end
      end
      FBD_WR: begin
        if (cnt_zero) begin
          // rising strobe latches; data held one more cycle
          nxt_pins.strobe_n = 1'b1;
          nxt_state         = FBD_WR_END;
        end
      end
      FBD_WR_END: begin
        nxt_pins.sel_n = 1'b1;
        nxt_oe         = 1'b0;
        nxt_state      = FBD_IDLE;
      end
      FBD_RST: begin
        if (cnt_zero) begin
          nxt_pins.init_n = 1'b1;
          nxt_cnt         = cyc(fbd_pkg::INIT_REC_CYC);
          nxt_state       = FBD_REC;
        end
      end
      FBD_REC: begin
        // ready returns here so cut-off work can be reissued
        if (cnt_zero) begin
          nxt_state = FBD_IDLE;
        end
      end
      default: begin
        nxt_state = FBD_IDLE;
      end
    endcase
  end

  // state registers; reset leaves the pins idle and reset high
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_ff  <= FBD_IDLE;
      cnt_ff    <= '0;
      pins_ff   <= '{sel_n: 1'b1, gate_n: 1'b1, strobe_n: 1'b1,
                     init_n: 1'b1, byte_addr_in: '0};
      dout_ff   <= '0;
      oe_ff     <= 1'b0;
      rvalid_ff <= 1'b0;
      rdata_ff  <= '0;
      busy_ff   <= 1'b0;
    end else begin
      state_ff  <= nxt_state;
      cnt_ff    <= nxt_cnt;
      pins_ff   <= nxt_pins;
      dout_ff   <= nxt_dout;
      oe_ff     <= nxt_oe;
      rvalid_ff <= nxt_rvalid;
      rdata_ff  <= nxt_rdata;
      // busy while done flag reads low
      busy_ff   <= busy_sync;
    end
  end

  // ready is combinational-free: registered idle marker
  logic ready_ff;
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ready_ff <= 1'b0;
    end else begin
      ready_ff <= (nxt_state == FBD_IDLE) && !idle_take;
    end
  end

  assign o_req_ready  = ready_ff;
  assign o_rsp_valid  = rvalid_ff;
  assign o_rsp_data   = rdata_ff;
  assign o_dev_busy   = busy_ff;
  assign o_pins       = pins_ff;
  assign o_data_io    = dout_ff;
  assign o_data_io_oe = oe_ff;

  // never drive data while the output gate is low
  no_contend_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    oe_ff |-> pins_ff.gate_n) else $error("data driven with gate low");

  rd_strobe_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    !pins_ff.gate_n |-> pins_ff.strobe_n && !pins_ff.sel_n && pins_ff.init_n)
    else $error("read levels wrong");

  // reset pulse stays low for at least 8 cycles after its fall
  sequence init_fall_s;
    $fell(pins_ff.init_n);
  endsequence
  rst_width_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    init_fall_s |-> !pins_ff.init_n [*8]) else $error("reset pulse short");

  // no select right after reset rises
  rec_gap_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    $rose(pins_ff.init_n) |-> pins_ff.sel_n [*5]) else $error("recovery");

  // no read response within 8 cycles of the gate falling
  rd_late_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    $fell(pins_ff.gate_n) |-> !o_rsp_valid [*8]) else $error("early data");

  // cycles the reset pin has stayed low; the full width is too long
  // for a repetition, so it is counted here and checked at the rise
  logic [fbd_pkg::CNT_W-1:0] low_cnt_ff;
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      low_cnt_ff <= '0;
    end else begin
      low_cnt_ff <= pins_ff.init_n ? '0 : low_cnt_ff + 1'b1;
    end
  end

  // pulse counted to its end is at least the minimum width
  sequence init_rise_s;
    $rose(pins_ff.init_n);
  endsequence
  rst_full_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    init_rise_s |-> low_cnt_ff >= fbd_pkg::INIT_PULSE_CYC)
    else $error("reset pulse below minimum width");

  // strobe low only with select low, gate high, data driven
  wr_levels_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    !pins_ff.strobe_n |-> !pins_ff.sel_n && pins_ff.gate_n && oe_ff)
    else $error("write levels wrong");
endmodule : fbd_host

// ===== dv/fbd_dev_model.sv
// behavioural flash device answering the host's pins
`timescale 1ns/1ns
module fbd_dev_model #(
  parameter logic [7:0] ID_CODE = 8'h5A, // arbitrary value
  parameter logic [7:0] STATUS  = 8'h40,
  parameter int         ACC_NS  = 110,
  parameter int         BUSY_NS = 3000,
  parameter int         RDY_NS  = 400
) (
  // pins from the host
  input  wire fbd_pkg::fbd_pins_type i_pins,
  input  wire logic [7:0]            i_data_io,
  // device outputs
  output logic [7:0]                 o_data_io,
  output logic                       o_op_done_flag
);
  logic       id_mode    = 1'b0;
  logic       acc_ok     = 1'b0;
  logic [7:0] last       = 8'h00;
  logic [7:0] val;
  time        busy_until = 0;
  time        sel_t      = 0;
  wire        rd = !i_pins.sel_n && !i_pins.gate_n && i_pins.init_n;

  // data only after select access time; a stored fall time, not a
  // delay, so a short write cycle cannot swallow the next select edge
  always @(negedge i_pins.sel_n) sel_t = $time;

  // latch a command only on a strobe rise
  always @(posedge i_pins.strobe_n) begin
    if (!i_pins.sel_n && i_pins.gate_n && i_pins.init_n &&
        $time >= busy_until) begin
      case (i_data_io)
        8'h90: id_mode = 1'b1;
        8'hF0: id_mode = 1'b0;
        default: busy_until = $time + BUSY_NS;
      endcase
    end
  end

  // reset aborts work and returns to array mode
  always @(negedge i_pins.init_n) begin
    id_mode = 1'b0;
    if ($time < busy_until) busy_until = $time + RDY_NS;
  end

  // off-edge poll; floated bus shows inverse byte
  initial begin
    #2;
    forever begin
      #5;
      o_op_done_flag = ($time >= busy_until);
      acc_ok = !i_pins.sel_n && ($time - sel_t >= ACC_NS);
      val = !o_op_done_flag ? STATUS : id_mode ? ID_CODE :
            i_pins.byte_addr_in[7:0] ^ i_pins.byte_addr_in[19:12];
      if (rd && acc_ok) last = val;
      o_data_io = (rd && acc_ok) ? val : ~last;
    end
  end
endmodule : fbd_dev_model

// ===== dv/tb.sv
// self-checking bench for the flash bus host against a device model
`timescale 1ns/1ns
module tb;
  localparam logic [7:0] ID_CODE = 8'h5A; // arbitrary value
  localparam logic [7:0] STAT    = 8'h40;
  localparam fbd_pkg::fbd_req_type RD = fbd_pkg::FBD_REQ_READ;
  localparam fbd_pkg::fbd_req_type WR = fbd_pkg::FBD_REQ_WRITE;
  logic                  i_sys_clk   = 1'b0;
  logic                  i_reset_n   = 1'b0;
  logic                  i_req_valid = 1'b0;
  fbd_pkg::fbd_cmd_type  i_req_cmd   = '0;
  logic                  o_req_ready, o_rsp_valid, o_dev_busy;
  logic                  o_data_io_oe, done;
  logic [7:0]            o_rsp_data, o_data_io, dev_data;
  fbd_pkg::fbd_pins_type o_pins;
  int                    n_errors    = 0;
  int                    checks_done = 0;
  int                    cnt;
  // host wins the shared bus while it drives, else the device
  wire  [7:0]            data_io = o_data_io_oe ? o_data_io : dev_data;

  fbd_host dut (.i_sys_clk, .i_reset_n, .i_req_valid, .i_req_cmd,
    .o_req_ready, .o_rsp_valid, .o_rsp_data, .o_dev_busy, .o_pins,
    .i_data_io(data_io), .o_data_io, .o_data_io_oe, .i_op_done_flag(done));
  fbd_dev_model #(.ID_CODE(ID_CODE), .STATUS(STAT)) dev (.i_pins(o_pins),
    .i_data_io(data_io), .o_data_io(dev_data), .o_op_done_flag(done));

  // free-running system clock
  initial forever #5 i_sys_clk = ~i_sys_clk;

  task automatic end_sim;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_sim

  task automatic chk(input string nm, input logic [19:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // bounded wait on a flag: 0 ready, 1 rsp, 2 idle device, 3 busy
  task automatic wait_for(input int k, input int lim);
    logic [3:0] s;
    repeat (lim) begin
      @(negedge i_sys_clk);
      s = {o_dev_busy, !o_dev_busy, o_rsp_valid, o_req_ready};
      if (s[k] === 1'b1) return;
    end
    n_errors++;
    $display("ERROR wait %0d expected 1 seen 0", k);
    end_sim;
  endtask : wait_for

  // extra leading edge lets a lagging ready fall first
  task automatic req(input fbd_pkg::fbd_req_type k, input logic [19:0] a,
                     input logic [7:0] d);
    @(negedge i_sys_clk);
    wait_for(0, 100);
    i_req_cmd = '{k, a, d};
    i_req_valid = 1'b1;
    @(negedge i_sys_clk);
    i_req_valid = 1'b0;
    @(negedge i_sys_clk);
  endtask : req

  task automatic rd(input logic [19:0] a, input logic [7:0] e);
    req(RD, a, 8'h00);
    chk("rd pins", {o_pins.sel_n, o_pins.gate_n, o_pins.strobe_n},
        3'b001);
    chk("rd addr", o_pins.byte_addr_in, a);
    wait_for(1, 30);
    chk("rd data", o_rsp_data, e);
  endtask : rd

  task automatic wr(input logic [19:0] a, input logic [7:0] d);
    req(WR, a, d);
    chk("wr pins", {o_pins.sel_n, o_pins.gate_n, o_pins.strobe_n,
        o_data_io_oe}, 4'b0101);
    chk("wr data", o_data_io, d);
  endtask : wr

  function automatic logic [7:0] arr(input logic [19:0] a);
    return a[7:0] ^ a[19:12];
  endfunction : arr

  task automatic t_array;
    chk("idle pins", {o_pins.sel_n, o_pins.init_n, o_data_io_oe},
        3'b110);
    rd(20'h0_0000, arr(20'h0_0000));
    rd(20'hF_FFFF, arr(20'hF_FFFF));
    rd(20'hA_5C3E, arr(20'hA_5C3E));
    $display("test array done");
  endtask : t_array

  task automatic t_ident;
    wr(20'h0_0555, 8'h90);
    rd(20'h1_2345, ID_CODE);
    rd(20'h7_0001, ID_CODE);
    wr(20'h0_0555, 8'hF0);
    rd(20'h7_0001, arr(20'h7_0001));
    $display("test ident done");
  endtask : t_ident

  task automatic t_busy;
    wr(20'h3_0000, 8'hA0);
    wait_for(3, 20);
    rd(20'h3_0000, STAT);
    wait_for(2, 400);
    rd(20'h3_0000, arr(20'h3_0000));
    $display("test busy done");
  endtask : t_busy

  task automatic t_reset;
    wr(20'h0_0555, 8'h90);
    wr(20'h5_0000, 8'hA0);
    wait_for(3, 20);
    req(fbd_pkg::FBD_REQ_RESET, 20'h0_0000, 8'h00);
    for (cnt = 0; o_pins.init_n === 1'b0 && cnt < 200; cnt++)
      @(negedge i_sys_clk);
    chk("pulse width", cnt >= fbd_pkg::INIT_PULSE_CYC - 1, 1'b1);
    for (cnt = 0; o_req_ready !== 1'b1 && cnt < 50; cnt++)
      @(negedge i_sys_clk);
    chk("recovery", cnt >= fbd_pkg::INIT_REC_CYC, 1'b1);
    chk("busy cleared", o_dev_busy, 1'b0);
    rd(20'h5_0000, arr(20'h5_0000));
    wr(20'h5_0000, 8'hA0);
    wait_for(3, 20);
    wait_for(2, 400);
    $display("test reset done");
  endtask : t_reset

  // reset, then the scenarios in turn
  initial begin
    repeat (10) @(negedge i_sys_clk);
    i_reset_n = 1'b1;
    t_array;
    t_ident;
    t_busy;
    t_reset;
    end_sim;
  end
endmodule : tb
